/* File: hw/ccie_exec.sv */
// The plain strobed port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
// Functional notes
// - Clear working: working register becomes zero, zero flag set always.
// - Call pushes current program counter plus one onto the return stack.
// - Call loads its eight-bit literal into program counter bits seven to zero.
// - Call copies status page bits into counter bits ten, nine; bit eight cleared.
// - Call takes two cycles and leaves every status flag as it was.
// - Watchdog clear resets the watchdog counter to zero.
// - Watchdog clear zeroes the prescaler only while it is assigned to the watchdog.
// - Watchdog clear sets both active-low timeout and power-down status bits.
// - Clear file writes zero to any addressed file register and sets zero flag.
// - Complement gives the bitwise inverse of the file register, updates zero flag.
// - Destination bit zero sends result to working register, one to the file.
// - Decrement subtracts one from the file register into the chosen destination.
// - Increment adds one to the file register into the chosen destination.
module ccie_exec
	import ccie_pkg::*;
#(
	parameter int STACK_DEPTH = ccie_pkg::STACK_DEPTH_DEF,
	parameter int WDT_W = ccie_pkg::WDT_W_DEF,
	parameter int PRE_W = ccie_pkg::PRE_W_DEF
) (
	input wire logic ref_clk_i,
	input wire logic sys_rst_i,
	input wire logic clk_en_i,
	input wire logic instr_valid_i,
	input ccie_pkg::ccie_instr_t instr_i,
	input ccie_pkg::ccie_bus_req_t bus_i,
	input wire logic wdt_tick_i,
	input wire logic timer_tick_i,
	output logic [ccie_pkg::DATA_W-1:0] rd_data_o,
	output logic [ccie_pkg::DATA_W-1:0] w_o,
	output logic [ccie_pkg::DATA_W-1:0] status_o,
	output logic [ccie_pkg::PC_W-1:0] pc_o,
	output logic busy_o,
	output logic done_o,
	output logic wdt_timeout_o
);

	import ccie_pkg::*;

	initial begin
		if (STACK_DEPTH < 1 || WDT_W < 1 || WDT_W > DATA_W || PRE_W < 1 || PRE_W > DATA_W) begin
			$error("ccie_exec: stack depth must be positive and counter widths 1 to 8.");
		end
	end

	ccie_state_t state_reg;
	ccie_state_t state_next;
	logic [DATA_W-1:0] w_reg;
	logic [DATA_W-1:0] status_reg;
	logic [DATA_W-1:0] option_reg;
	logic [PC_W-1:0] pc_reg;
	logic [DATA_W-1:0] file_reg [FILE_DEPTH];
	logic [WDT_W-1:0] wdt_reg;
	logic [PRE_W-1:0] pre_reg;
	logic [DATA_W-1:0] rd_data_reg;
	logic done_reg;
	logic timeout_reg;
	logic [PC_W-1:0] stack_top;

	logic take;
	logic [DATA_W-1:0] file_val;
	logic [DATA_W-1:0] alu_res;
	logic to_w;
	logic to_f;
	logic z_upd;
	logic z_val;
	logic call_go;
	logic wdt_clr;
	logic [PC_W-1:0] call_target;
	logic [PC_W-1:0] pc_inc;
	logic psa;
	logic wdt_adv;
	logic wdt_wrap;
	logic bus_file_wr;
	logic [FILE_AW-1:0] bus_file_idx;
	logic w_bus_wr;
	logic status_bus_wr;
	logic pc_lo_bus_wr;
	logic pc_hi_bus_wr;
	logic option_bus_wr;
	logic wdt_bus_wr;
	logic pre_bus_wr;
	logic busy_reg;

	assign take = clk_en_i && instr_valid_i && (state_reg == ST_EXEC);
	assign file_val = file_reg[instr_i.file_addr];
	assign pc_inc = pc_reg + PC_ONE;
	assign psa = option_reg[OPT_PSA_BIT];
	assign bus_file_wr = bus_i.wr && !bus_i.addr[BUS_FILE_BIT];
	assign bus_file_idx = bus_i.addr[FILE_AW-1:0];
	// Write strobes decode once so that each register block only has to weigh priority.
	assign w_bus_wr = bus_i.wr && (bus_i.addr == ADDR_W_REG);
	assign status_bus_wr = bus_i.wr && (bus_i.addr == ADDR_STATUS);
	assign pc_lo_bus_wr = bus_i.wr && (bus_i.addr == ADDR_PC_LO);
	assign pc_hi_bus_wr = bus_i.wr && (bus_i.addr == ADDR_PC_HI);
	assign option_bus_wr = bus_i.wr && (bus_i.addr == ADDR_OPTION);
	assign wdt_bus_wr = bus_i.wr && (bus_i.addr == ADDR_WDT);
	assign pre_bus_wr = bus_i.wr && (bus_i.addr == ADDR_PRESCALER);
	// Page bits come from status as it stands when the call is taken.
	assign call_target = {status_reg[ST_PAGE_HI:ST_PAGE_LO], 1'b0, instr_i.literal};

	always_comb begin
		alu_res = ZERO_BYTE;
		to_w = 1'b0;
		to_f = 1'b0;
		z_upd = 1'b0;
		call_go = 1'b0;
		wdt_clr = 1'b0;
		if (take) begin
			case (instr_i.op)
				OP_CLEAR_WORKING_INSTR: begin
					alu_res = ZERO_BYTE;
					to_w = 1'b1;
					z_upd = 1'b1;
				end
				OP_CLEAR_FILE_INSTR: begin
					alu_res = ZERO_BYTE;
					to_f = 1'b1;
					z_upd = 1'b1;
				end
				OP_COMPLEMENT_FILE_INSTR: begin
					alu_res = ~file_val;
					to_w = !instr_i.dest_file;
					to_f = instr_i.dest_file;
					z_upd = 1'b1;
				end
				OP_DECREMENT_FILE_INSTR: begin
					alu_res = file_val - ONE_BYTE;
					to_w = !instr_i.dest_file;
					to_f = instr_i.dest_file;
					z_upd = 1'b1;
				end
				OP_INCREMENT_FILE_INSTR: begin
					alu_res = file_val + ONE_BYTE;
					to_w = !instr_i.dest_file;
					to_f = instr_i.dest_file;
					z_upd = 1'b1;
				end
				OP_CALL_INSTR: begin
					call_go = 1'b1;
				end
				OP_WATCHDOG_CLEAR_INSTR: begin
					wdt_clr = 1'b1;
				end
				default: begin
				end
			endcase
		end
	end

	assign z_val = (alu_res == ZERO_BYTE);

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_EXEC: begin
				if (call_go) begin
					state_next = ST_CALL_FLUSH;
				end
			end
			ST_CALL_FLUSH: begin
				state_next = ST_EXEC;
			end
			default: begin
				state_next = ST_EXEC;
			end
		endcase
	end

	// While busy the fetched successor is discarded, so new instructions are refused.
	// Busy is registered from the next state so that the output comes straight from a flop.
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			state_reg <= ST_EXEC;
			busy_reg <= 1'b0;
			done_reg <= 1'b0;
		end else if (clk_en_i) begin
			state_reg <= state_next;
			busy_reg <= (state_next == ST_CALL_FLUSH);
			done_reg <= (take && !call_go) || (state_reg == ST_CALL_FLUSH);
		end
	end

	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			w_reg <= W_RST;
		end else if (clk_en_i) begin
			if (to_w) begin
				w_reg <= alu_res;
			end else if (w_bus_wr) begin
				w_reg <= bus_i.wdata;
			end
		end
	end

	// Instruction effects on single status bits take precedence over a bus write.
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			status_reg <= STATUS_RST;
		end else if (clk_en_i) begin
			if (status_bus_wr) begin
				status_reg <= bus_i.wdata;
			end
			if (z_upd) begin
				status_reg[ST_Z_BIT] <= z_val;
			end
			if (wdt_clr) begin
				status_reg[ST_PD_BIT] <= 1'b1;
				status_reg[ST_TO_BIT] <= 1'b1;
			end
			if (wdt_wrap) begin
				status_reg[ST_TO_BIT] <= 1'b0;
			end
		end
	end

	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			pc_reg <= PC_RST;
		end else if (clk_en_i) begin
			if (call_go) begin
				pc_reg <= call_target;
			end else if (take) begin
				pc_reg <= pc_inc;
			end else if (pc_lo_bus_wr) begin
				pc_reg[PC_LIT_HI:0] <= bus_i.wdata;
			end else if (pc_hi_bus_wr) begin
				pc_reg[PC_W-1:PC_LIT_HI+1] <= bus_i.wdata[PC_HI_W-1:0];
			end
		end
	end

	// The stack top is readable on the bus so that software can check the return address.
	ccie_stack #(
		.DEPTH(STACK_DEPTH),
		.WIDTH(PC_W)
	) u_stack (
		.ref_clk_i(ref_clk_i),
		.sys_rst_i(sys_rst_i),
		.clk_en_i(clk_en_i),
		.push_i(call_go),
		.push_data_i(pc_inc),
		.top_o(stack_top)
	);

	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			for (int i = 0; i < FILE_DEPTH; i++) begin
				file_reg[i] <= ZERO_BYTE;
			end
		end else if (clk_en_i) begin
			if (bus_file_wr && !(to_f && bus_file_idx == instr_i.file_addr)) begin
				file_reg[bus_file_idx] <= bus_i.wdata;
			end
			if (to_f) begin
				file_reg[instr_i.file_addr] <= alu_res;
			end
		end
	end

	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			option_reg <= OPTION_RST;
		end else if (clk_en_i && option_bus_wr) begin
			option_reg <= bus_i.wdata;
		end
	end

	// With the prescaler on the watchdog, the watchdog only advances when the prescaler wraps.
	assign wdt_adv = psa ? (wdt_tick_i && (&pre_reg)) : wdt_tick_i;
	assign wdt_wrap = wdt_adv && (&wdt_reg) && !wdt_clr;

	// A clear in the same cycle as a wrap suppresses the timeout, so the clear always wins.
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			wdt_reg <= '0;
			timeout_reg <= 1'b0;
		end else if (clk_en_i) begin
			timeout_reg <= wdt_wrap;
			if (wdt_clr) begin
				wdt_reg <= '0;
			end else if (wdt_bus_wr) begin
				wdt_reg <= bus_i.wdata[WDT_W-1:0];
			end else if (wdt_adv) begin
				wdt_reg <= wdt_reg + WDT_W'(1'b1);
			end
		end
	end

	// The prescaler serves one consumer at a time; its assignment bit picks the tick it counts.
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			pre_reg <= '0;
		end else if (clk_en_i) begin
			if (wdt_clr && psa) begin
				pre_reg <= '0;
			end else if (pre_bus_wr) begin
				pre_reg <= bus_i.wdata[PRE_W-1:0];
			end else if (psa ? wdt_tick_i : timer_tick_i) begin
				pre_reg <= pre_reg + PRE_W'(1'b1);
			end
		end
	end

	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			rd_data_reg <= ZERO_BYTE;
		end else if (clk_en_i) begin
			rd_data_reg <= ZERO_BYTE;
			if (bus_i.rd) begin
				if (!bus_i.addr[BUS_FILE_BIT]) begin
					rd_data_reg <= file_reg[bus_file_idx];
				end else begin
					case (bus_i.addr)
						ADDR_W_REG: rd_data_reg <= w_reg;
						ADDR_STATUS: rd_data_reg <= status_reg;
						ADDR_PC_LO: rd_data_reg <= pc_reg[PC_LIT_HI:0];
						ADDR_PC_HI: rd_data_reg <= {{(DATA_W-PC_HI_W){1'b0}}, pc_reg[PC_W-1:PC_LIT_HI+1]};
						ADDR_OPTION: rd_data_reg <= option_reg;
						ADDR_WDT: rd_data_reg <= DATA_W'(wdt_reg);
						ADDR_PRESCALER: rd_data_reg <= DATA_W'(pre_reg);
						ADDR_STACK_LO: rd_data_reg <= stack_top[PC_LIT_HI:0];
						ADDR_STACK_HI: rd_data_reg <= {{(DATA_W-PC_HI_W){1'b0}}, stack_top[PC_W-1:PC_LIT_HI+1]};
						default: rd_data_reg <= ZERO_BYTE;
					endcase
				end
			end
		end
	end

	assign rd_data_o = rd_data_reg;
	assign w_o = w_reg;
	assign status_o = status_reg;
	assign pc_o = pc_reg;
	assign busy_o = busy_reg;
	assign done_o = done_reg;
	assign wdt_timeout_o = timeout_reg;

endmodule

/* File: hw/ccie_pkg.sv */
package ccie_pkg;

	localparam int DATA_W = 8;
	localparam int FILE_AW = 5;
	localparam int FILE_DEPTH = 32;
	localparam int PC_W = 11;
	localparam int BUS_AW = 6;
	localparam int STACK_DEPTH_DEF = 2;
	localparam int WDT_W_DEF = 8;
	localparam int PRE_W_DEF = 8;

	localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
	localparam logic [DATA_W-1:0] ONE_BYTE = 8'h01;
	localparam logic [PC_W-1:0] PC_ONE = 11'h001;
	localparam logic [PC_W-1:0] PC_RST = 11'h000;
	localparam logic [DATA_W-1:0] W_RST = 8'h00;
	localparam logic [DATA_W-1:0] STATUS_RST = 8'h18;
	localparam logic [DATA_W-1:0] OPTION_RST = 8'h08;

	localparam int ST_Z_BIT = 2;
	localparam int ST_PD_BIT = 3;
	localparam int ST_TO_BIT = 4;
	localparam int ST_PAGE_LO = 5;
	localparam int ST_PAGE_HI = 6;
	localparam int OPT_PSA_BIT = 3;
	localparam int PC_LIT_HI = 7;
	localparam int PC_HI_W = 3;
	localparam int BUS_FILE_BIT = 5;

	localparam logic [BUS_AW-1:0] ADDR_W_REG = 6'h20;
	localparam logic [BUS_AW-1:0] ADDR_STATUS = 6'h21;
	localparam logic [BUS_AW-1:0] ADDR_PC_LO = 6'h22;
	localparam logic [BUS_AW-1:0] ADDR_PC_HI = 6'h23;
	localparam logic [BUS_AW-1:0] ADDR_OPTION = 6'h24;
	localparam logic [BUS_AW-1:0] ADDR_WDT = 6'h25;
	localparam logic [BUS_AW-1:0] ADDR_PRESCALER = 6'h26;
	localparam logic [BUS_AW-1:0] ADDR_STACK_LO = 6'h27;
	localparam logic [BUS_AW-1:0] ADDR_STACK_HI = 6'h28;

	typedef enum logic [2:0] {
		OP_NOP = 3'h0,
		OP_CLEAR_WORKING_INSTR = 3'h1,
		OP_CALL_INSTR = 3'h2,
		OP_WATCHDOG_CLEAR_INSTR = 3'h3,
		OP_CLEAR_FILE_INSTR = 3'h4,
		OP_COMPLEMENT_FILE_INSTR = 3'h5,
		OP_DECREMENT_FILE_INSTR = 3'h6,
		OP_INCREMENT_FILE_INSTR = 3'h7
	} ccie_op_t;

	typedef enum logic [1:0] {
		ST_EXEC = 2'b01,
		ST_CALL_FLUSH = 2'b10
	} ccie_state_t;

	typedef struct packed {
		ccie_op_t op;
		logic [FILE_AW-1:0] file_addr;
		logic dest_file;
		logic [DATA_W-1:0] literal;
	} ccie_instr_t;

	typedef struct packed {
		logic [BUS_AW-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic wr;
		logic rd;
	} ccie_bus_req_t;

endpackage

/* File: hw/ccie_stack.sv */
`timescale 1ns/1ps
module ccie_stack #(
	parameter int DEPTH = 2,
	parameter int WIDTH = 11
) (
	input wire logic ref_clk_i,
	input wire logic sys_rst_i,
	input wire logic clk_en_i,
	input wire logic push_i,
	input wire logic [WIDTH-1:0] push_data_i,
	output logic [WIDTH-1:0] top_o
);

	logic [WIDTH-1:0] entry_reg [DEPTH];

	initial begin
		if (DEPTH < 1 || WIDTH < 1) begin
			$error("ccie_stack: DEPTH and WIDTH must be at least one.");
		end
	end

	// A push beyond the depth drops the oldest entry, as a fixed hardware stack does.
	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			for (int i = 0; i < DEPTH; i++) begin
				entry_reg[i] <= '0;
			end
		end else if (clk_en_i && push_i) begin
			entry_reg[0] <= push_data_i;
			for (int i = 1; i < DEPTH; i++) begin
				entry_reg[i] <= entry_reg[i-1];
			end
		end
	end

	assign top_o = entry_reg[0];

endmodule

/* File: test/ccie_exec_asserts.sv */
`timescale 1ns/1ps
module ccie_exec_asserts
	import ccie_pkg::*;
(
	input wire logic ref_clk_i,
	input wire logic sys_rst_i,
	input wire logic clk_en_i,
	input wire logic instr_valid_i,
	input ccie_pkg::ccie_instr_t instr_i,
	input ccie_pkg::ccie_bus_req_t bus_i,
	input logic [ccie_pkg::DATA_W-1:0] w_o,
	input logic [ccie_pkg::DATA_W-1:0] status_o,
	input logic [ccie_pkg::PC_W-1:0] pc_o,
	input logic busy_o,
	input logic done_o
);
	logic go;
	logic alu;
	assign go = clk_en_i && instr_valid_i && !busy_o;
	assign alu = instr_i.op inside {OP_COMPLEMENT_FILE_INSTR, OP_DECREMENT_FILE_INSTR, OP_INCREMENT_FILE_INSTR};
	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (sys_rst_i);
	a_call_two_cycle: assert property (go && instr_i.op == OP_CALL_INSTR |=> busy_o && !done_o ##1 done_o && !busy_o)
		else $error("call length wrong");
	a_single_done: assert property (go && instr_i.op != OP_CALL_INSTR |=> done_o && !busy_o)
		else $error("single cycle op not done");
	a_call_pc_form: assert property (go && instr_i.op == OP_CALL_INSTR |=>
		pc_o == {$past(status_o[ST_PAGE_HI:ST_PAGE_LO]), 1'b0, $past(instr_i.literal)})
		else $error("call target wrong");
	a_call_flags_kept: assert property (go && instr_i.op == OP_CALL_INSTR && !bus_i.wr |=> $stable(status_o))
		else $error("call changed status");
	a_clear_working_instr_result: assert property (go && instr_i.op == OP_CLEAR_WORKING_INSTR |=> w_o == 8'h00 && status_o[ST_Z_BIT])
		else $error("clear working wrong");
	a_wdtclr_bits: assert property (go && instr_i.op == OP_WATCHDOG_CLEAR_INSTR |=>
		status_o[ST_TO_BIT] && status_o[ST_PD_BIT])
		else $error("watchdog clear status bits wrong");
	a_clear_file_instr_zero: assert property (go && instr_i.op == OP_CLEAR_FILE_INSTR |=> status_o[ST_Z_BIT])
		else $error("clear file zero flag wrong");
	a_file_dest_keep: assert property (go && alu && instr_i.dest_file && !bus_i.wr |=> w_o == $past(w_o))
		else $error("file destination touched working");
	a_z_follows: assert property (go && alu && !instr_i.dest_file |=> status_o[ST_Z_BIT] == (w_o == 8'h00))
		else $error("zero flag does not follow result");
	c_call: cover property (go && instr_i.op == OP_CALL_INSTR);
	c_wdt_clear: cover property (go && instr_i.op == OP_WATCHDOG_CLEAR_INSTR);
	c_file_dest: cover property (go && alu && instr_i.dest_file);
endmodule
bind ccie_exec ccie_exec_asserts u_chk (.ref_clk_i, .sys_rst_i, .clk_en_i, .instr_valid_i, .instr_i, .bus_i,
	.w_o, .status_o, .pc_o, .busy_o, .done_o);

/* File: test/ccie_exec_tb.sv */
`timescale 1ns/1ps
module ccie_exec_tb;
	import ccie_pkg::*;
	logic ref_clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic instr_valid_i = 1'b0;
	ccie_instr_t instr_i = '0;
	ccie_bus_req_t bus_i = '0;
	logic [DATA_W-1:0] rd_data_o, w_o, status_o;
	logic [PC_W-1:0] pc_o;
	logic busy_o, done_o, wdt_timeout_o;
	logic rd_pend = 1'b0;
	logic [7:0] exp_q[$];
	logic [7:0] st = STATUS_RST;
	logic clk_en = 1'b1;
	logic wdt_tick = 1'b0;
	logic [31:0] seed = 32'h00000D0D;
	int fail_count = 0;
	int n_compared = 0;
	int cyc = 0;
	ccie_op_t ops[3] = '{OP_COMPLEMENT_FILE_INSTR, OP_DECREMENT_FILE_INSTR, OP_INCREMENT_FILE_INSTR};
	always #2 ref_clk_i = ~ref_clk_i;
	// The timer tick stays low so that the prescaler holds still between writes and reads.
	ccie_exec DUT (.ref_clk_i, .sys_rst_i, .clk_en_i(clk_en), .instr_valid_i, .instr_i, .bus_i, .wdt_tick_i(wdt_tick),
		.timer_tick_i(1'b0), .rd_data_o, .w_o, .status_o, .pc_o, .busy_o, .done_o, .wdt_timeout_o);
	function automatic logic [7:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed[7:0];
	endfunction
	task automatic close_out();
		$display("counts: %0d compared, %0d mismatches", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic bus(input logic [5:0] a, input logic [7:0] d, input logic wr);
		@(posedge ref_clk_i);
		bus_i <= '{addr: a, wdata: d, wr: wr, rd: !wr};
		@(posedge ref_clk_i);
		bus_i <= '0;
	endtask
	task automatic rd(input logic [5:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		bus(a, 8'h00, 1'b0);
	endtask
	task automatic ex(input ccie_op_t op, input logic [4:0] f, input logic d, input logic [7:0] k);
		@(posedge ref_clk_i);
		instr_valid_i <= 1'b1;
		instr_i <= '{op: op, file_addr: f, dest_file: d, literal: k};
		@(posedge ref_clk_i);
		instr_valid_i <= 1'b0;
		if (op == OP_CALL_INSTR)
			@(posedge ref_clk_i);
	endtask
	always @(posedge ref_clk_i) begin
		cyc <= cyc + 1;
		rd_pend <= bus_i.rd;
		if (cyc == 5000) begin
			fail_count++;
			$display("[ERR] %0t timeout", $time);
			close_out();
		end else if (rd_pend) begin
			n_compared++;
			if (exp_q.size() == 0 || rd_data_o !== exp_q[0]) begin
				fail_count++;
				$display("[ERR] %0t read data %h", $time, rd_data_o);
			end
			if (exp_q.size() > 0)
				void'(exp_q.pop_front());
		end
	end
	initial begin
		logic [7:0] v;
		logic [7:0] r;
		logic [4:0] a;
		logic d;
		repeat (10) @(posedge ref_clk_i);
		sys_rst_i <= 1'b0;
		bus(ADDR_W_REG, 8'h5A, 1'b1);
		ex(OP_CLEAR_WORKING_INSTR, 5'h00, 1'b0, 8'h00);
		st[ST_Z_BIT] = 1'b1;
		rd(ADDR_W_REG, 8'h00);
		rd(ADDR_STATUS, st);
		$display("test clear working done");
		// Values 00, 01 and FF hit the wrap and zero cases; the fourth is random.
		for (int i = 0; i < 24; i++) begin
			v = (i[1:0] == 2'h3) ? rnd() : ((i[1:0] == 2'h2) ? 8'hFF : {6'h00, i[1:0]});
			r = rnd();
			a = r[4:0];
			d = i[2];
			bus({1'b0, a}, v, 1'b1);
			bus(ADDR_W_REG, 8'hC3, 1'b1);
			ex(ops[i / 8], a, d, 8'h00);
			r = (i < 8) ? ~v : ((i < 16) ? v - 8'h01 : v + 8'h01);
			st[ST_Z_BIT] = (r == 8'h00);
			rd(ADDR_W_REG, d ? 8'hC3 : r);
			rd({1'b0, a}, d ? r : v);
			rd(ADDR_STATUS, st);
		end
		$display("test file arithmetic done");
		bus(6'h1F, 8'hA5, 1'b1);
		ex(OP_CLEAR_FILE_INSTR, 5'h1F, 1'b0, 8'h00);
		st[ST_Z_BIT] = 1'b1;
		rd(6'h1F, 8'h00);
		rd(ADDR_STATUS, st);
		$display("test clear file done");
		st[6:5] = 2'b11;
		r = rnd();
		bus(ADDR_STATUS, st, 1'b1);
		bus(ADDR_PC_LO, 8'hFF, 1'b1);
		bus(ADDR_PC_HI, 8'h01, 1'b1);
		ex(OP_CALL_INSTR, 5'h00, 1'b0, r);
		rd(ADDR_PC_LO, r);
		rd(ADDR_PC_HI, 8'h06);
		rd(ADDR_STACK_LO, 8'h00);
		rd(ADDR_STACK_HI, 8'h02);
		rd(ADDR_STATUS, st);
		$display("test call done");
		for (int j = 0; j < 2; j++) begin
			bus(ADDR_OPTION, (j == 1) ? 8'h00 : 8'h08, 1'b1);
			st[4:3] = 2'b00;
			bus(ADDR_STATUS, st, 1'b1);
			bus(ADDR_WDT, 8'h33, 1'b1);
			bus(ADDR_PRESCALER, 8'h44, 1'b1);
			ex(OP_WATCHDOG_CLEAR_INSTR, 5'h00, 1'b0, 8'h00);
			st[4:3] = 2'b11;
			rd(ADDR_WDT, 8'h00);
			rd(ADDR_PRESCALER, (j == 1) ? 8'h44 : 8'h00);
			rd(ADDR_STATUS, st);
		end
		rd(6'h30, 8'h00);
		$display("test watchdog clear done");
		// With the prescaler on the timer, one tick at all ones wraps the watchdog for one pulse.
		bus(ADDR_WDT, 8'hFF, 1'b1);
		@(posedge ref_clk_i);
		wdt_tick <= 1'b1;
		@(posedge ref_clk_i);
		wdt_tick <= 1'b0;
		@(posedge ref_clk_i);
		n_compared++;
		if (wdt_timeout_o !== 1'b1) begin
			fail_count++;
			$display("[ERR] %0t timeout pulse missing", $time);
		end
		@(posedge ref_clk_i);
		n_compared++;
		if (wdt_timeout_o !== 1'b0) begin
			fail_count++;
			$display("[ERR] %0t timeout pulse too long", $time);
		end
		st[ST_TO_BIT] = 1'b0;
		rd(ADDR_WDT, 8'h00);
		rd(ADDR_STATUS, st);
		$display("test watchdog wrap done");
		// Nothing may change while the clock enable is low, bus writes and instructions included.
		@(posedge ref_clk_i);
		clk_en <= 1'b0;
		bus(ADDR_W_REG, 8'h77, 1'b1);
		ex(OP_CLEAR_WORKING_INSTR, 5'h00, 1'b0, 8'h00);
		@(posedge ref_clk_i);
		clk_en <= 1'b1;
		rd(ADDR_W_REG, 8'hC3);
		rd(ADDR_STATUS, st);
		$display("test clock enable freeze done");
		repeat (2) @(posedge ref_clk_i);
		close_out();
	end
endmodule
